// file: rtl/bles_defines.svh
// Purpose: constants for the loader entry control block
// Assumes: 250 MHz reference clock
// Notes:   definitions only
`ifndef BLES_DEFINES_SVH
`define BLES_DEFINES_SVH
// ==========================================================
// password and memory probe
`define BLES_PWD_W        256
`define BLES_WORD_W       32
`define BLES_BLANK_WORD   32'hffffffff
// ==========================================================
// factory configuration: loader enabled, entry level high, fast boot off
`define BLES_CFG_EN_RST   1'b1
`define BLES_CFG_LVL_RST  1'b1
`define BLES_CFG_FAST_RST 1'b0
// ==========================================================
// boot settle time before the entry pin is judged
`define BLES_SETTLE_NS    40
`define BLES_CLK_NS       4
`define BLES_SETTLE_CYC   ((`BLES_SETTLE_NS + `BLES_CLK_NS - 1) / `BLES_CLK_NS)
`define BLES_CNT_W        4
`endif

// file: rtl/bles_pkg.sv
// Purpose: types for the loader entry control block
// Assumes: nothing
// Notes:   one-hot boot states
`default_nettype none
package bles_pkg;
    // ======================================================
    // boot sequence states
    typedef enum logic [4:0] {
        BLES_ST_SETTLE = 5'b00001,
        BLES_ST_PROBE  = 5'b00010,
        BLES_ST_DECIDE = 5'b00100,
        BLES_ST_LOADER = 5'b01000,
        BLES_ST_APP    = 5'b10000
    } bles_state_t;
    // link selection
    typedef enum logic [1:0] {
        BLES_LINK_NONE = 2'b00,
        BLES_LINK_UART = 2'b01,
        BLES_LINK_I2C  = 2'b10
    } bles_link_t;
endpackage : bles_pkg
`default_nettype wire

// file: rtl/bles_entry_ctrl.sv
// Purpose: decide loader or application at boot, gate access by password
// Assumes: arst_n_in is the boot reset, fed by external_reset_pin_n
// Notes:   serial protocol engines sit outside; this block owns entry and gating
//          the decision is taken once per boot and only a reset can revisit it
//          the password compare is a plain 256-bit equality, one try per cycle that pwd_valid_in is high
// Operation
// - loader programs memory and configuration via uart/i2c
// - access refused until 256-bit password matches
// - configuration can disable the loader entirely
// - factory default has loader enabled
// - every entry path requires loader enabled
// - entry pin matching configured level starts loader
// - fast boot skips the entry pin check
// - blank reset vector and stack pointer start loader
// - software reset with loader command starts loader
// - entry pin is active-high digital input
// - low external reset resets, then pin rechecked
// - link uses uart rx/tx or i2c scl/sda
`include "bles_defines.svh"
`default_nettype none
module bles_entry_ctrl (
    // clock and boot reset
    input  wire logic                     ref_clk_in,
    input  wire logic                     arst_n_in,
    // device configuration
    input  wire logic                     cfg_loader_en_in,
    input  wire logic                     cfg_entry_level_in,
    input  wire logic                     cfg_fast_boot_in,
    input  wire logic                     cfg_valid_in,
    input  wire logic [`BLES_PWD_W-1:0]   cfg_password_in,
    // boot inputs
    input  wire logic                     loader_entry_pin_in,
    input  wire logic [`BLES_WORD_W-1:0]  reset_vector_in,
    input  wire logic [`BLES_WORD_W-1:0]  stack_pointer_in,
    input  wire logic                     sw_loader_cmd_in,
    // host password presentation from the loader engine
    input  wire logic                     pwd_valid_in,
    input  wire logic [`BLES_PWD_W-1:0]   pwd_value_in,
    // link pins
    input  wire logic                     loader_uart_receive_in,
    output logic                          loader_uart_transmit_out,
    input  wire logic                     loader_i2c_clock_in,
    input  wire logic                     loader_i2c_data_in,
    output logic                          loader_i2c_data_oe_n_out,
    // engine-side link
    input  wire logic                     eng_uart_tx_in,
    input  wire logic                     eng_i2c_pull_low_in,
    output logic                          eng_uart_rx_out,
    output logic                          eng_i2c_clock_out,
    output logic                          eng_i2c_data_out,
    output logic [1:0]                    link_sel_out,
    // decision and gating
    output logic                          decided_out,
    output logic                          loader_active_out,
    output logic                          app_start_out,
    output logic                          access_granted_out,
    output logic                          pwd_reject_out
);
    import bles_pkg::*;

    // ======================================================
    // pin synchronisers: three stages, change accepted when last two agree
    logic [2:0] pin_sync_ff;
    logic       pin_level_ff;
    logic [2:0] ser_pin;       // 0 rx, 1 scl, 2 sda
    logic [2:0] ser_level;     // filtered serial levels, same order
    logic       rx_level;
    logic       scl_level;
    logic       sda_level;

    // entry pin idles low because it is active high
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_sync_ff  <= 3'h0;
            pin_level_ff <= 1'b0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[1:0], loader_entry_pin_in};
            if (pin_sync_ff[1] == pin_sync_ff[2]) begin
                pin_level_ff <= pin_sync_ff[2];
            end
        end
    end

    // serial lines idle high, so reset loads ones and no false start follows it
    // one identical filter per serial pin
    assign ser_pin = {loader_i2c_data_in, loader_i2c_clock_in, loader_uart_receive_in};

    for (genvar g = 0; g < 3; g++) begin : g_ser_sync
        logic [2:0] sync_ff;
        logic       level_ff;

        // a level is accepted only once the last two stages agree
        always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                sync_ff  <= 3'h7;
                level_ff <= 1'b1;
            end else begin
                sync_ff <= {sync_ff[1:0], ser_pin[g]};
                if (sync_ff[1] == sync_ff[2]) begin
                    level_ff <= sync_ff[2];
                end
            end
        end

        assign ser_level[g] = level_ff;
    end : g_ser_sync

    // named taps for the router and the engine side
    assign rx_level  = ser_level[0];
    assign scl_level = ser_level[1];
    assign sda_level = ser_level[2];

    // ======================================================
    // configuration capture after reset release
    // configuration is taken once settled so a mid-boot change cannot flip it
    // command and blank words are taken even with unprogrammed configuration,
    // since both paths must work on a factory-fresh part
    logic cfg_en_ff;
    logic cfg_lvl_ff;
    logic cfg_fast_ff;
    logic sw_cmd_ff;
    logic blank_ff;
    logic nxt_blank;

    assign nxt_blank = (reset_vector_in == `BLES_BLANK_WORD) &&
                       (stack_pointer_in == `BLES_BLANK_WORD);

    // ======================================================
    // boot sequence
    // timeline after reset release:
    //   settle  - the entry pin clears its filter before it is judged
    //   probe   - configuration, command and blank words are captured
    //   decide  - the entry request is judged exactly once
    //   loader or app - held until the next boot reset
    // trade-off: a fixed settle wait costs a few cycles of boot time but
    // needs no handshake with whatever drives the entry pin
    bles_state_t             state_ff;
    bles_state_t             nxt_state;
    logic [`BLES_CNT_W-1:0]  settle_cnt_ff;
    logic                    entry_req;
    logic                    pin_hit;
    logic                    blank_hit;
    logic                    sw_hit;

    // state decodes shared by the gate, the link router and the outputs
    function automatic logic in_loader(input bles_state_t s);
        return s == BLES_ST_LOADER;
    endfunction : in_loader

    function automatic logic is_decided(input bles_state_t s);
        return (s == BLES_ST_LOADER) || (s == BLES_ST_APP);
    endfunction : is_decided

    // settle timer lets the entry pin pass the synchroniser
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            settle_cnt_ff <= '0;
        end else if (state_ff == BLES_ST_SETTLE) begin
            settle_cnt_ff <= settle_cnt_ff + `BLES_CNT_W'(1);
        end
    end

    // unprogrammed flash defaults to loader-enabled entry
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cfg_en_ff   <= `BLES_CFG_EN_RST;
            cfg_lvl_ff  <= `BLES_CFG_LVL_RST;
            cfg_fast_ff <= `BLES_CFG_FAST_RST;
            sw_cmd_ff   <= 1'b0;
            blank_ff    <= 1'b0;
        end else if (state_ff == BLES_ST_PROBE) begin
            if (cfg_valid_in) begin
                cfg_en_ff   <= cfg_loader_en_in;
                cfg_lvl_ff  <= cfg_entry_level_in;
                cfg_fast_ff <= cfg_fast_boot_in;
            end
            sw_cmd_ff <= sw_loader_cmd_in;
            blank_ff  <= nxt_blank;
        end
    end

    // any of three invocation paths, all behind the enable
    // kept as separate terms so each path can be traced on its own
    assign pin_hit   = !cfg_fast_ff && (pin_level_ff == cfg_lvl_ff);
    assign blank_hit = blank_ff;
    assign sw_hit    = sw_cmd_ff;
    assign entry_req = cfg_en_ff && (pin_hit || blank_hit || sw_hit);

    // next-state logic: loader and app are terminal until reset
    // no default branch: every one-hot code is listed and reset loads a legal one
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            BLES_ST_SETTLE: begin
                if (settle_cnt_ff == `BLES_CNT_W'(`BLES_SETTLE_CYC - 1)) begin
                    nxt_state = BLES_ST_PROBE;
                end
            end
            BLES_ST_PROBE: begin
                nxt_state = BLES_ST_DECIDE;
            end
            BLES_ST_DECIDE: begin
                nxt_state = entry_req ? BLES_ST_LOADER : BLES_ST_APP;
            end
            BLES_ST_LOADER: begin
                nxt_state = BLES_ST_LOADER;
            end
            BLES_ST_APP: begin
                nxt_state = BLES_ST_APP;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff <= BLES_ST_SETTLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ======================================================
    // password gate
    // limitation: the stored password is read live, so it must stay steady
    // while the loader runs; a wrong try costs one cycle and may be retried
    logic granted_ff;
    logic reject_ff;
    logic pwd_try;
    logic pwd_match;

    // a try counts only inside the loader and before a grant
    assign pwd_try   = in_loader(state_ff) && pwd_valid_in && !granted_ff;
    assign pwd_match = (pwd_value_in == cfg_password_in);

    // grant is sticky until reset; a wrong try pulses reject for one cycle
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            granted_ff <= 1'b0;
            reject_ff  <= 1'b0;
        end else begin
            reject_ff <= 1'b0;
            if (pwd_try) begin
                if (pwd_match) begin
                    granted_ff <= 1'b1;
                end else begin
                    reject_ff <= 1'b1;
                end
            end
        end
    end

    // ======================================================
    // link routing: first activity picks the link, locked until reset
    // hazard: activity on both links in one cycle resolves to the uart; once
    // locked the choice cannot move, so a noisy idle line can claim the loader
    bles_link_t link_ff;
    logic       tx_ff;
    logic       sda_oe_n_ff;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            link_ff <= BLES_LINK_NONE;
        end else if (in_loader(state_ff) && link_ff == BLES_LINK_NONE) begin
            if (!rx_level) begin
                link_ff <= BLES_LINK_UART;
            end else if (!sda_level && scl_level) begin
                link_ff <= BLES_LINK_I2C;
            end
        end
    end

    // registered pin drive; open-drain sda enabled low while pulling low
    // registered so that no decode glitch reaches a pin that leaves the chip
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tx_ff       <= 1'b1;
            sda_oe_n_ff <= 1'b1;
        end else begin
            tx_ff       <= (link_ff == BLES_LINK_UART) ? eng_uart_tx_in : 1'b1;
            sda_oe_n_ff <= !((link_ff == BLES_LINK_I2C) && eng_i2c_pull_low_in);
        end
    end

    // ======================================================
    // outputs; path flags decode the one-hot register, so they cannot glitch
    assign loader_uart_transmit_out = tx_ff;
    assign loader_i2c_data_oe_n_out = sda_oe_n_ff;
    assign eng_uart_rx_out          = rx_level;
    assign eng_i2c_clock_out        = scl_level;
    assign eng_i2c_data_out         = sda_level;
    assign link_sel_out             = link_ff;
    assign decided_out              = is_decided(state_ff);
    assign loader_active_out        = in_loader(state_ff);
    assign app_start_out            = (state_ff == BLES_ST_APP);
    assign access_granted_out       = granted_ff;
    assign pwd_reject_out           = reject_ff;
endmodule : bles_entry_ctrl
`default_nettype wire

// file: tb/bles_entry_ctrl_sva.sv
// Purpose: port checker for bles_entry_ctrl
// Assumes: cfg held steady across each boot
// Notes:   bound from the bench top file
`include "bles_defines.svh"
`default_nettype none
module bles_entry_ctrl_sva (
    // clock, reset and inputs
    input wire logic                   ref_clk_in,
    input wire logic                   arst_n_in,
    input wire logic                   cfg_loader_en_in,
    input wire logic                   cfg_valid_in,
    input wire logic [`BLES_PWD_W-1:0] cfg_password_in,
    input wire logic                   pwd_valid_in,
    input wire logic [`BLES_PWD_W-1:0] pwd_value_in,
    // watched outputs
    input wire logic                   decided_out,
    input wire logic                   loader_active_out,
    input wire logic                   app_start_out,
    input wire logic                   access_granted_out,
    input wire logic                   pwd_reject_out,
    input wire logic                   loader_uart_transmit_out,
    input wire logic                   loader_i2c_data_oe_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // edges since release, saturating so it never wraps
    logic [3:0] cnt_ff;
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) cnt_ff <= 4'h0;
        else if (cnt_ff != 4'hf) cnt_ff <= cnt_ff + 4'h1;
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    decide_time_a: assert property (decided_out == (cnt_ff >= 4'hc))
        else $error("decision at wrong edge");
    one_path_a: assert property (decided_out |-> loader_active_out ^ app_start_out)
        else $error("not exactly one path");
    path_held_a: assert property (decided_out |=> $stable(loader_active_out))
        else $error("path changed after decision");
    enable_gate_a: assert property ($rose(loader_active_out) |-> cfg_loader_en_in || !cfg_valid_in)
        else $error("loader entered while disabled");
    grant_match_a: assert property (pwd_valid_in && loader_active_out && !access_granted_out
        && pwd_value_in == cfg_password_in |=> access_granted_out && !pwd_reject_out)
        else $error("good password not granted");
    reject_bad_a: assert property (pwd_valid_in && loader_active_out && !access_granted_out
        && pwd_value_in != cfg_password_in |=> pwd_reject_out && !access_granted_out)
        else $error("bad password not rejected");
    grant_gated_a: assert property (access_granted_out |-> loader_active_out ##1 access_granted_out)
        else $error("grant outside loader or dropped");
    reject_cause_a: assert property (pwd_reject_out |-> $past(pwd_valid_in))
        else $error("reject without a password");
    link_idle_a: assert property (!decided_out |-> loader_uart_transmit_out && loader_i2c_data_oe_n_out)
        else $error("link driven before decision");
    cover property ($rose(loader_active_out));
    cover property ($rose(app_start_out));
    cover property ($rose(access_granted_out));
endmodule : bles_entry_ctrl_sva
`default_nettype wire

// file: tb/bles_host_model.sv
// Purpose: external programming host on the loader pins
// Assumes: sda has a pull-up, wired-and with the device
// Notes:   tasks are called by the bench
`include "bles_defines.svh"
`default_nettype none
module bles_host_model (
    // clock and device sda enable
    input  wire logic                   clk_in,
    input  wire logic                   oe_n_in,
    // pins and password frame
    output logic                        external_reset_pin_n_out,
    output logic                        pin_out,
    output logic                        rx_out,
    output logic                        scl_out,
    output logic                        sda_out,
    output logic                        pwd_valid_out,
    output logic [`BLES_PWD_W-1:0]      pwd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic host_sda = 1'b1;
    // ==========================================================
    // open-drain sda: either side pulls low, else pull-up wins
    assign sda_out = host_sda & oe_n_in;
    initial begin
        {external_reset_pin_n_out, pin_out, pwd_valid_out, pwd_out} = '0;
        {rx_out, scl_out} = 2'h3;
    end
    // hold entry level through a reset pulse, link idle high
    task automatic boot(input logic pin, input int len);
        @(posedge clk_in);
        #1;
        {external_reset_pin_n_out, pin_out, rx_out, host_sda} = {1'b0, pin, 2'h3};
        repeat (len) @(posedge clk_in);
        #1;
        external_reset_pin_n_out = 1'b1;
    endtask : boot
    // whole 256-bit password in one frame, then junk on the bus
    task automatic send_pwd(input logic [`BLES_PWD_W-1:0] v);
        @(posedge clk_in);
        #1;
        {pwd_valid_out, pwd_out} = {1'b1, v};
        @(posedge clk_in);
        #1;
        {pwd_valid_out, pwd_out} = {1'b0, ~v};
    endtask : send_pwd
    // uart start bit, or i2c start with scl high
    task automatic start(input logic i2c);
        @(posedge clk_in);
        #1;
        if (i2c) host_sda = 1'b0;
        else rx_out = 1'b0;
    endtask : start
endmodule : bles_host_model
`default_nettype wire

// file: tb/bles_entry_ctrl_bench.sv
// Purpose: self-checking bench for bles_entry_ctrl
// Assumes: cfg changes only before each boot reset pulse, never mid-boot
// Notes:   six fixed corners, then random boots
`include "bles_defines.svh"
`default_nettype none
module bles_entry_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import bles_pkg::*;
    logic ref_clk_in = 1'b0, cfg_loader_en_in = 1'b0, cfg_entry_level_in = 1'b0, cfg_fast_boot_in = 1'b0;
    logic cfg_valid_in = 1'b0, sw_loader_cmd_in = 1'b0, eng_uart_tx_in = 1'b1, eng_i2c_pull_low_in = 1'b0;
    logic [`BLES_PWD_W-1:0] cfg_password_in = '0, pwd_value_in;
    logic [`BLES_WORD_W-1:0] reset_vector_in = '0, stack_pointer_in = '0;
    logic arst_n_in, loader_entry_pin_in, pwd_valid_in, loader_uart_receive_in, loader_i2c_clock_in;
    logic loader_i2c_data_in, loader_uart_transmit_out, loader_i2c_data_oe_n_out, eng_uart_rx_out;
    logic eng_i2c_clock_out, eng_i2c_data_out, decided_out, loader_active_out, app_start_out;
    logic access_granted_out, pwd_reject_out;
    logic [1:0] link_sel_out;
    int fails = 0, n_checks = 0, seed = 32'he75c93c9;
    // corner boots {valid, en, level, fast, sw, pin, blank}
    logic [6:0] corner [6] = '{7'b0000010, 7'b1010111, 7'b1101000, 7'b1110001, 7'b1100110, 7'b1100000};
    always #2 ref_clk_in = ~ref_clk_in;
    bles_entry_ctrl u_dut (.ref_clk_in, .arst_n_in, .cfg_loader_en_in, .cfg_entry_level_in, .cfg_fast_boot_in,
        .cfg_valid_in, .cfg_password_in, .loader_entry_pin_in, .reset_vector_in, .stack_pointer_in,
        .sw_loader_cmd_in, .pwd_valid_in, .pwd_value_in, .loader_uart_receive_in, .loader_uart_transmit_out,
        .loader_i2c_clock_in, .loader_i2c_data_in, .loader_i2c_data_oe_n_out, .eng_uart_tx_in,
        .eng_i2c_pull_low_in, .eng_uart_rx_out, .eng_i2c_clock_out, .eng_i2c_data_out, .link_sel_out,
        .decided_out, .loader_active_out, .app_start_out, .access_granted_out, .pwd_reject_out);
    bles_host_model u_host (.clk_in(ref_clk_in), .oe_n_in(loader_i2c_data_oe_n_out), .external_reset_pin_n_out(arst_n_in),
        .pin_out(loader_entry_pin_in), .rx_out(loader_uart_receive_in), .scl_out(loader_i2c_clock_in),
        .sda_out(loader_i2c_data_in), .pwd_valid_out(pwd_valid_in), .pwd_out(pwd_value_in));
    // ==========================================================
    // expected path; factory defaults apply while cfg is unprogrammed
    function automatic logic exp_loader(input logic [6:0] c);
        logic en, lvl;
        en = c[6] ? c[5] : `BLES_CFG_EN_RST;
        lvl = c[6] ? c[4] : `BLES_CFG_LVL_RST;
        return en & ((!(c[6] & c[3]) & (c[1] == lvl)) | c[0] | c[2]);
    endfunction : exp_loader
    task automatic chk_bit(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_bit
    task automatic chk_sel(input logic [1:0] g, input logic [1:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_sel
    task automatic stop_test();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    initial begin
        logic [31:0] r;
        logic [6:0] c;
        logic exp_l;
        logic [`BLES_PWD_W-1:0] bad;
        int k;
        for (int i = 0; i < 30; i++) begin
            r = $random(seed);
            c = (i < 6) ? corner[i] : r[6:0];
            @(posedge ref_clk_in);
            #1;
            {cfg_valid_in, cfg_loader_en_in, cfg_entry_level_in, cfg_fast_boot_in, sw_loader_cmd_in} = c[6:2];
            {eng_uart_tx_in, eng_i2c_pull_low_in} = 2'h2;
            reset_vector_in = (c[0] | r[7]) ? `BLES_BLANK_WORD : 32'h00000101;
            stack_pointer_in = c[0] ? `BLES_BLANK_WORD : 32'h20000ffc;
            for (k = 0; k < 8; k++) cfg_password_in[k*32 +: 32] = $random(seed);
            u_host.boot(c[1], (i == 0) ? 20 : 1 + int'(r[9:8]));
            for (k = 0; k < 40 && decided_out !== 1'b1; k++) begin
                @(posedge ref_clk_in);
                #1;
            end
            if (k == 40) begin
                fails++;
                stop_test();
            end
            exp_l = exp_loader(c);
            chk_bit(loader_active_out, exp_l);
            chk_bit(app_start_out, !exp_l);
            bad = cfg_password_in ^ ({`BLES_PWD_W{1'b0}} | 1'b1) << r[15:8];
            u_host.send_pwd(bad);
            chk_bit(pwd_reject_out, exp_l);
            u_host.send_pwd(cfg_password_in);
            chk_bit(access_granted_out, exp_l);
            u_host.send_pwd(bad);
            chk_bit(pwd_reject_out, 1'b0);
            if (exp_l) begin
                u_host.start(r[16]);
                for (k = 0; k < 12 && link_sel_out === 2'b00; k++) begin
                    @(posedge ref_clk_in);
                    #1;
                end
                if (k == 12) begin
                    fails++;
                    stop_test();
                end
                chk_sel(link_sel_out, r[16] ? BLES_LINK_I2C : BLES_LINK_UART);
                chk_bit(eng_uart_rx_out, r[16]);
                chk_bit(eng_i2c_data_out, !r[16]);
                chk_bit(eng_i2c_clock_out, 1'b1);
                {eng_uart_tx_in, eng_i2c_pull_low_in} = r[11:10];
                repeat (2) @(posedge ref_clk_in);
                #1;
                chk_bit(loader_i2c_data_oe_n_out, !(r[16] & r[10]));
                chk_bit(loader_uart_transmit_out, r[16] | r[11]);
            end
            $display("test %0d done loader=%0b", i, exp_l);
        end
        stop_test();
    end
endmodule : bles_entry_ctrl_bench
bind bles_entry_ctrl bles_entry_ctrl_sva u_sva (.ref_clk_in, .arst_n_in, .cfg_loader_en_in, .cfg_valid_in,
    .cfg_password_in, .pwd_valid_in, .pwd_value_in, .decided_out, .loader_active_out, .app_start_out,
    .access_granted_out, .pwd_reject_out, .loader_uart_transmit_out, .loader_i2c_data_oe_n_out);
`default_nettype wire
